// File: shared/fast_pwm_pkg.sv
/* Constants and carrier types of the fast PWM control slice.
   Assumes an 8-bit I/O port with one-cycle strobes. */
package fast_pwm_pkg;

    // Register offsets on the 6-bit I/O port.
    localparam logic [5:0] OFS_OVERRIDE   = 6'h00;
    localparam logic [5:0] OFS_PLL_CTRL   = 6'h29;
    localparam logic [5:0] OFS_FAULT_WAVE = 6'h26;
    localparam logic [5:0] OFS_CNT_LOW    = 6'h2E;
    localparam logic [5:0] OFS_CNT_HIGH   = 6'h25;

    // Field positions in the fault and waveform control register.
    localparam int FW_IRQ_EN   = 7;
    localparam int FW_MODE_EN  = 6;
    localparam int FW_FILT_EN  = 5;
    localparam int FW_EDGE_SEL = 4;
    localparam int FW_CMP_EN   = 3;
    localparam int FW_FLAG     = 2;

    // Field positions in the PLL control and status register.
    localparam int PL_LOW_SPEED = 7;
    localparam int PL_FAST_SEL  = 2;
    localparam int PL_PLL_EN    = 1;
    localparam int PL_LOCK      = 0;

    // Reset values and fixed codes.
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [5:0] OVR_MASK      = 6'h3F;
    localparam logic [3:0] FUSE_PLL_CODE = 4'h1;
    localparam logic [9:0] CNT_ZERO      = 10'h000;

    // Noise filter length in samples.
    localparam int FILT_SAMPLES = 4;

    // Counter write latency: 1.5 cycles rounds up, at most one stays one.
    localparam logic [1:0] WR_DLY_SYNC  = 2'h2;
    localparam logic [1:0] WR_DLY_ASYNC = 2'h1;

    // Counter modes; Gray coded along normal -> fast -> phase correct -> six-output.
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b000,
        MODE_FAST     = 3'b001,
        MODE_PFC      = 3'b011,
        MODE_SIX_SGL  = 3'b010,
        MODE_SIX_DUAL = 3'b110
    } cnt_mode_e;

    // One access on the I/O register port.
    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } io_req_s;

    // Compare outputs of the three waveform channels.
    typedef struct packed {
        logic a;
        logic b;
        logic d;
    } cmp_out_s;

endpackage

// File: hdl/fault_noise_filter.sv
/* Fault input noise filter.
   Assumes a raw input synchronous to clk_sys_in. */
`timescale 1ns/1ns
module fault_noise_filter
#(
    parameter int SAMPLES = fast_pwm_pkg::FILT_SAMPLES
)(
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    input  wire logic filt_en_in,
    input  wire logic raw_in,
    output logic      filt_out
);
    import fast_pwm_pkg::*;

    logic [SAMPLES-1:0] hist_ff;
    logic [SAMPLES-1:0] nxt_hist;
    logic               filt_ff;
    logic               nxt_filt;

    ////////////////////////////////////////////////////////////////////////////
    // With the filter enabled, output changes only when every stored sample agrees and differs from it.
    always_comb
    begin
        nxt_hist = {hist_ff[SAMPLES-2:0], raw_in};
        nxt_filt = filt_ff;
        if (!filt_en_in)
        begin
            nxt_filt = raw_in;
        end
        else if (&nxt_hist)
        begin
            nxt_filt = 1'b1;
        end
        else if (~|nxt_hist)
        begin
            nxt_filt = 1'b0;
        end
    end

    // Registers only; ce freezes the history too.
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            hist_ff <= '0;
            filt_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            hist_ff <= nxt_hist;
            filt_ff <= nxt_filt;
        end
    end

    assign filt_out = filt_ff;

endmodule // fault_noise_filter

// File: hdl/fast_pwm_ctrl.sv
/* Control slice of a 10-bit fast PWM timer.
   Assumes one-cycle I/O strobes and prescaler ticks from outside. */
`timescale 1ns/1ns

// What this block does
// - Filter needs four equal samples to change
// - Comparator feeds fault front end when enabled
// - Fault pin raises request even as output
// - Flag clears on vector or write-one
// - Interrupt needs global, enable and flag
// - PWM enable and field pick mode
// - Top is compare C; update/overflow points
// - Override bit connects compare output to pin in six-output modes
// - Bits pair to A, B, D pins
// - Low speed halves clock; refused on PLL
// - Fast select picks peripheral clock ticks
// - Fast select settable only with PLL enabled
// - PLL enable starts PLL; reads one on PLL
// - Lock indicator is read-only status
// - Counter write lands after set delay
// - Counter write forces up-counting
// - Shared 2-bit high byte, upper zero
// - Override register upper bits read zero
// - Fault mode enable lets faults act
module fast_pwm_ctrl
(
    input  wire logic                 clk_sys_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ce_in,
    input  wire fast_pwm_pkg::io_req_s io_req_in,
    output logic [7:0]                io_rdata_out,
    input  wire logic                 fault_input_pin_in,
    input  wire logic                 comparator_in,
    input  wire logic                 fault_vector_ack_in,
    input  wire logic                 global_irq_en_in,
    output logic                      fault_irq_out,
    output logic                      fault_shutdown_out,
    input  wire logic                 pwm_enable_a_in,
    input  wire logic                 pwm_enable_b_in,
    input  wire logic [9:0]           compare_top_reg_in,
    input  wire logic                 sys_tick_in,
    input  wire logic                 pck_tick_in,
    output logic [9:0]                counter_out,
    output logic                      overflow_pulse_out,
    output logic                      compare_update_out,
    output logic [2:0]                mode_out,
    input  wire fast_pwm_pkg::cmp_out_s compare_outs_in,
    input  wire logic [5:0]           port_reg_in,
    output logic [5:0]                pin_out,
    input  wire logic [3:0]           clock_source_fuse_in,
    input  wire logic                 pll_lock_ind_in,
    output logic                      pll_start_out,
    output logic                      async_clk_sel_out
);
    import fast_pwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    logic [7:0] fw_ctrl_ff, nxt_fw_ctrl;
    logic [5:0] ovr_ff, nxt_ovr;
    logic       low_speed_ff, nxt_low_speed;
    logic       fast_sel_ff, nxt_fast_sel;
    logic       pll_en_ff, nxt_pll_en;
    logic       clr_pend_ff, nxt_clr_pend;
    logic       filt_prev_ff, nxt_filt_prev;
    logic [1:0] hi_tmp_ff, nxt_hi_tmp;
    logic [9:0] cnt_ff, nxt_cnt;
    logic       down_ff, nxt_down;
    logic [1:0] wr_dly_ff, nxt_wr_dly;
    logic [9:0] wr_val_ff, nxt_wr_val;
    logic       half_ff, nxt_half;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       irq_ff, nxt_irq;
    logic       shut_ff, nxt_shut;
    logic       ovf_ff, nxt_ovf;
    logic       upd_ff, nxt_upd;
    logic [5:0] pin_ff, nxt_pin;
    logic [2:0] mode_out_ff;
    logic       pll_start_ff;

    logic      fault_raw;
    logic      fault_filt;
    logic      pll_is_sys;
    logic      pll_running;
    logic      tick;
    logic      pwm_on;
    cnt_mode_e mode;

    // True for an access to the given offset on the given strobe.
    function automatic logic hit(input logic strobe, input logic [5:0] ofs);
        hit = strobe && (io_req_in.addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Fault and clock source decode.
    // The pin is read straight from the pad, so an output-driven pin still trips it.
    assign fault_raw   = fw_ctrl_ff[FW_CMP_EN] ? comparator_in : fault_input_pin_in;
    assign pll_is_sys  = (clock_source_fuse_in == FUSE_PLL_CODE);
    assign pll_running = pll_en_ff || pll_is_sys;
    // Low speed keeps every other fast tick; the fast clock itself lives outside.
    assign tick        = fast_sel_ff ? (pck_tick_in && (!low_speed_ff || half_ff)) : sys_tick_in;
    assign pwm_on      = pwm_enable_a_in || pwm_enable_b_in;

    fault_noise_filter #(
        .SAMPLES (FILT_SAMPLES)
    ) u_filter (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .ce_in      (ce_in),
        .filt_en_in (fw_ctrl_ff[FW_FILT_EN]),
        .raw_in     (fault_raw),
        .filt_out   (fault_filt)
    );

    // Mode from PWM enable and the waveform field.
    always_comb
    begin
        mode = MODE_NORMAL;
        if (pwm_on)
        begin
            case (fw_ctrl_ff[1:0])
                2'b00:   mode = MODE_FAST;
                2'b01:   mode = MODE_PFC;
                2'b10:   mode = MODE_SIX_SGL;
                default: mode = MODE_SIX_DUAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register, flag and clock control next values.
    always_comb
    begin
        logic edge_hit;
        logic wr_fw;
        edge_hit      = 1'b0;
        wr_fw         = hit(io_req_in.wr, OFS_FAULT_WAVE);
        nxt_fw_ctrl   = fw_ctrl_ff;
        nxt_ovr       = ovr_ff;
        nxt_low_speed = low_speed_ff;
        nxt_fast_sel  = fast_sel_ff;
        nxt_pll_en    = pll_en_ff;
        nxt_clr_pend  = 1'b0;
        nxt_filt_prev = fault_filt;
        nxt_hi_tmp    = hi_tmp_ff;
        nxt_rdata     = rdata_ff;
        nxt_half      = (fast_sel_ff && pck_tick_in) ? !half_ff : half_ff;

        // Edge select picks which transition of the filtered input counts.
        if (fw_ctrl_ff[FW_EDGE_SEL])
        begin
            edge_hit = fault_filt && !filt_prev_ff;
        end
        else
        begin
            edge_hit = !fault_filt && filt_prev_ff;
        end

        if (wr_fw)
        begin
            nxt_fw_ctrl = {io_req_in.wdata[7:3], fw_ctrl_ff[FW_FLAG], io_req_in.wdata[1:0]};
            nxt_clr_pend = io_req_in.wdata[FW_FLAG];
        end
        // Write-one clear lands one cycle late; the vector clears at once.
        if (clr_pend_ff || fault_vector_ack_in)
        begin
            nxt_fw_ctrl[FW_FLAG] = 1'b0;
        end
        // A new event beats a clear in the same cycle.
        if (edge_hit)
        begin
            nxt_fw_ctrl[FW_FLAG] = 1'b1;
        end

        if (hit(io_req_in.wr, OFS_OVERRIDE))
        begin
            nxt_ovr = io_req_in.wdata[5:0] & OVR_MASK;
        end
        else if (hit(io_req_in.wr, OFS_PLL_CTRL))
        begin
            nxt_pll_en    = io_req_in.wdata[PL_PLL_EN];
            nxt_low_speed = io_req_in.wdata[PL_LOW_SPEED] && !pll_is_sys;
            nxt_fast_sel  = io_req_in.wdata[PL_FAST_SEL] && pll_running;
        end
        else if (hit(io_req_in.wr, OFS_CNT_HIGH))
        begin
            nxt_hi_tmp = io_req_in.wdata[1:0];
        end

        // Read mux; reserved bits read as zero.
        if (hit(io_req_in.rd, OFS_OVERRIDE))
        begin
            nxt_rdata = {2'b00, ovr_ff};
        end
        else if (hit(io_req_in.rd, OFS_PLL_CTRL))
        begin
            nxt_rdata = {low_speed_ff, 4'h0, fast_sel_ff, pll_running, pll_lock_ind_in};
        end
        else if (hit(io_req_in.rd, OFS_FAULT_WAVE))
        begin
            nxt_rdata = fw_ctrl_ff;
        end
        else if (hit(io_req_in.rd, OFS_CNT_LOW))
        begin
            nxt_rdata  = cnt_ff[7:0];
            nxt_hi_tmp = cnt_ff[9:8];
        end
        else if (hit(io_req_in.rd, OFS_CNT_HIGH))
        begin
            nxt_rdata = {6'h00, hi_tmp_ff};
        end
        else if (io_req_in.rd)
        begin
            nxt_rdata = RST_BYTE;
        end

        nxt_irq  = global_irq_en_in && nxt_fw_ctrl[FW_IRQ_EN] && nxt_fw_ctrl[FW_FLAG];
        nxt_shut = nxt_fw_ctrl[FW_MODE_EN] && nxt_fw_ctrl[FW_FLAG];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and pin next values.
    always_comb
    begin
        logic at_top;
        logic at_bot;
        logic dual;
        at_top     = (cnt_ff >= compare_top_reg_in);
        at_bot     = (cnt_ff == CNT_ZERO);
        dual       = (mode == MODE_PFC) || (mode == MODE_SIX_DUAL);
        nxt_cnt    = cnt_ff;
        nxt_down   = down_ff;
        nxt_wr_dly = wr_dly_ff;
        nxt_wr_val = wr_val_ff;
        nxt_ovf    = 1'b0;
        nxt_upd    = (mode == MODE_NORMAL);
        nxt_pin    = port_reg_in;

        // Count on the tick; dual slope turns at top and bottom.
        if (tick)
        begin
            if (dual)
            begin
                if (down_ff && at_bot)
                begin
                    nxt_down = 1'b0;
                    nxt_cnt  = cnt_ff + 10'h001;
                    nxt_ovf  = 1'b1;
                    nxt_upd  = 1'b1;
                end
                else if (!down_ff && at_top)
                begin
                    nxt_down = 1'b1;
                    nxt_cnt  = cnt_ff - 10'h001;
                end
                else
                begin
                    nxt_cnt = down_ff ? cnt_ff - 10'h001 : cnt_ff + 10'h001;
                end
            end
            else if (at_top)
            begin
                nxt_cnt  = CNT_ZERO;
                nxt_down = 1'b0;
                nxt_ovf  = 1'b1;
                nxt_upd  = 1'b1;
            end
            else
            begin
                nxt_cnt  = cnt_ff + 10'h001;
                nxt_down = 1'b0;
            end
        end

        // Written value waits out the clock-domain latency, then wins over counting.
        if (wr_dly_ff != 2'h0)
        begin
            nxt_wr_dly = wr_dly_ff - 2'h1;
            if (wr_dly_ff == 2'h1)
            begin
                nxt_cnt  = wr_val_ff;
                nxt_down = 1'b0;
            end
        end
        if (hit(io_req_in.wr, OFS_CNT_LOW))
        begin
            nxt_wr_val = {hi_tmp_ff, io_req_in.wdata};
            nxt_wr_dly = fast_sel_ff ? WR_DLY_ASYNC : WR_DLY_SYNC;
        end

        // Six-output modes: override bits pass channels to pins.
        if ((mode == MODE_SIX_SGL) || (mode == MODE_SIX_DUAL))
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (ovr_ff[i])
                begin
                    nxt_pin[i] = (i < 2) ? compare_outs_in.a :
                                 (i < 4) ? compare_outs_in.b : compare_outs_in.d;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // All registers; ce low freezes everything.
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            fw_ctrl_ff   <= RST_BYTE;
            ovr_ff       <= 6'h00;
            low_speed_ff <= 1'b0;
            fast_sel_ff  <= 1'b0;
            pll_en_ff    <= 1'b0;
            clr_pend_ff  <= 1'b0;
            filt_prev_ff <= 1'b0;
            hi_tmp_ff    <= 2'h0;
            cnt_ff       <= CNT_ZERO;
            down_ff      <= 1'b0;
            wr_dly_ff    <= 2'h0;
            wr_val_ff    <= CNT_ZERO;
            half_ff      <= 1'b0;
            rdata_ff     <= RST_BYTE;
            irq_ff       <= 1'b0;
            shut_ff      <= 1'b0;
            ovf_ff       <= 1'b0;
            upd_ff       <= 1'b0;
            pin_ff       <= 6'h00;
            mode_out_ff  <= MODE_NORMAL;
            pll_start_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            fw_ctrl_ff   <= nxt_fw_ctrl;
            ovr_ff       <= nxt_ovr;
            low_speed_ff <= nxt_low_speed;
            fast_sel_ff  <= nxt_fast_sel;
            pll_en_ff    <= nxt_pll_en;
            clr_pend_ff  <= nxt_clr_pend;
            filt_prev_ff <= nxt_filt_prev;
            hi_tmp_ff    <= nxt_hi_tmp;
            cnt_ff       <= nxt_cnt;
            down_ff      <= nxt_down;
            wr_dly_ff    <= nxt_wr_dly;
            wr_val_ff    <= nxt_wr_val;
            half_ff      <= nxt_half;
            rdata_ff     <= nxt_rdata;
            irq_ff       <= nxt_irq;
            shut_ff      <= nxt_shut;
            ovf_ff       <= nxt_ovf;
            upd_ff       <= nxt_upd;
            pin_ff       <= nxt_pin;
            mode_out_ff  <= mode;
            pll_start_ff <= pll_running;
        end
    end

    // Outputs straight from flip-flops.
    assign io_rdata_out       = rdata_ff;
    assign fault_irq_out      = irq_ff;
    assign fault_shutdown_out = shut_ff;
    assign counter_out        = cnt_ff;
    assign overflow_pulse_out = ovf_ff;
    assign compare_update_out = upd_ff;
    assign mode_out           = mode_out_ff;
    assign pin_out            = pin_ff;
    assign pll_start_out      = pll_start_ff;
    assign async_clk_sel_out  = fast_sel_ff;

endmodule // fast_pwm_ctrl

// File: bench/fast_pwm_ctrl_monitor.sv
/* Port checker for fast_pwm_ctrl.
   Assumes a bind from the bench top. */
`timescale 1ns/1ns
module fast_pwm_ctrl_monitor
    import fast_pwm_pkg::*;
(
    input  wire logic                  clk_sys_in,
    input  wire logic                  nrst_in,
    input  wire fast_pwm_pkg::io_req_s io_req_in,
    input  wire logic [7:0]            io_rdata_out,
    input  wire logic                  global_irq_en_in,
    input  wire logic                  fault_irq_out,
    input  wire logic                  overflow_pulse_out,
    input  wire logic                  compare_update_out,
    input  wire logic [2:0]            mode_out,
    input  wire logic [5:0]            port_reg_in,
    input  wire logic [5:0]            pin_out,
    input  wire logic [3:0]            clock_source_fuse_in,
    input  wire logic                  pll_lock_ind_in,
    input  wire logic                  pll_start_out,
    input  wire logic                  async_clk_sel_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////
    // A read strobe at one offset.
    sequence rd_of(logic [5:0] a);
        io_req_in.rd && io_req_in.addr == a;
    endsequence
    // Non six-output mode with a steady port value.
    sequence port_path;
        !(mode_out[1] && !mode_out[0]) && $stable(port_reg_in);
    endsequence
    ////////////////////////////////////////
    a_override_upper_zero: assert property (rd_of(OFS_OVERRIDE) |=> io_rdata_out[7:6] == 2'h0)
        else $error("override upper bits not zero");
    a_temp_upper_zero: assert property (rd_of(OFS_CNT_HIGH) |=> io_rdata_out[7:2] == 6'h00)
        else $error("high temp upper bits not zero");
    a_lock_read_live: assert property (rd_of(OFS_PLL_CTRL) |=> io_rdata_out[PL_LOCK] == $past(pll_lock_ind_in))
        else $error("lock bit not live");
    a_pll_reads_one: assert property (rd_of(OFS_PLL_CTRL) ##0 clock_source_fuse_in == FUSE_PLL_CODE
        |=> io_rdata_out[PL_PLL_EN]) else $error("pll enable not one with pll fuse");
    a_fuse_starts_pll: assert property (clock_source_fuse_in == FUSE_PLL_CODE |=> pll_start_out)
        else $error("pll not started by fuse");
    a_fast_needs_pll: assert property ($rose(async_clk_sel_out) |-> $past(pll_start_out))
        else $error("fast clock without pll");
    a_irq_needs_global: assert property (fault_irq_out |-> $past(global_irq_en_in))
        else $error("fault irq without global enable");
    a_update_in_normal: assert property ((mode_out == MODE_NORMAL) [*3] |-> compare_update_out)
        else $error("no update in normal mode");
    a_update_at_overflow: assert property (($stable(mode_out) && mode_out != MODE_NORMAL) [*2]
        |-> compare_update_out == overflow_pulse_out) else $error("update not with overflow");
    a_overflow_one_cycle: assert property (overflow_pulse_out |=> !overflow_pulse_out)
        else $error("overflow pulse too long");
    a_pins_track_port: assert property (port_path [*2] |-> pin_out == port_reg_in)
        else $error("pins do not show port value");
endmodule // fast_pwm_ctrl_monitor

// File: bench/power_stage_model.sv
/* Power stage beyond the PWM pins.
   Assumes the bench steers trips; the fault line idles high. */
`timescale 1ns/1ns
module power_stage_model
(
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic shutdown_in,
    input  wire logic trip_in,
    input  wire logic latch_in,
    output logic      fault_pin_out
);
    logic trip_latched_ff;
    logic nxt_trip_latched;
    // A latched trip keeps pulling until the stage is shut down, like a real overcurrent.
    always_comb
    begin
        nxt_trip_latched = trip_latched_ff;
        if (shutdown_in)
            nxt_trip_latched = 1'b0;
        else if (trip_in && latch_in)
            nxt_trip_latched = 1'b1;
    end
    // Latch register.
    always_ff @(posedge clk_sys_in)
        trip_latched_ff <= nrst_in ? nxt_trip_latched : 1'b0;
    // Open-drain line: the pull-up wins when nobody pulls low.
    assign fault_pin_out = !(trip_in || trip_latched_ff);
endmodule // power_stage_model

// File: bench/tb.sv
/* Self-checking bench for fast_pwm_ctrl with a power stage on the fault line.
   Assumes one 100 MHz clock; inputs change at the falling edge. */
`timescale 1ns/1ns
module tb;
    import fast_pwm_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       nrst_in = 1'b0;
    io_req_s    io_req = '0;
    logic       gie = 1'b0, ack = 1'b0, cmp = 1'b0, en_a = 1'b0, en_b = 1'b0, ce = 1'b1;
    logic       st = 1'b0, pt = 1'b0, lock = 1'b0, trip = 1'b0, latch = 1'b0;
    logic [9:0] top = 10'h010;
    cmp_out_s   cmp_o = '0;
    logic [5:0] port = 6'h00, pins;
    logic [3:0] fuse = 4'h0;
    logic [9:0] cnt;
    logic [7:0] rdata;
    logic [2:0] mode;
    logic       irq, shut, ovf, upd, pst, asel, fpin;
    int         miscompares = 0, tests_run = 0;
    // Free-running system clock.
    always #5 clk_sys_in = ~clk_sys_in;
    fast_pwm_ctrl fast_pwm_ctrl_i (.clk_sys_in, .nrst_in, .ce_in(ce), .io_req_in(io_req), .io_rdata_out(rdata),
        .fault_input_pin_in(fpin), .comparator_in(cmp), .fault_vector_ack_in(ack), .global_irq_en_in(gie),
        .fault_irq_out(irq), .fault_shutdown_out(shut), .pwm_enable_a_in(en_a), .pwm_enable_b_in(en_b),
        .compare_top_reg_in(top), .sys_tick_in(st), .pck_tick_in(pt), .counter_out(cnt),
        .overflow_pulse_out(ovf), .compare_update_out(upd), .mode_out(mode), .compare_outs_in(cmp_o),
        .port_reg_in(port), .pin_out(pins), .clock_source_fuse_in(fuse), .pll_lock_ind_in(lock),
        .pll_start_out(pst), .async_clk_sel_out(asel));
    power_stage_model power_stage_model_i (.clk_sys_in, .nrst_in, .shutdown_in(shut), .trip_in(trip),
        .latch_in(latch), .fault_pin_out(fpin));
    ////////////////////////////////////////
    task automatic check(string name, logic [9:0] exp, logic [9:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One write strobe; the idle cycle after it keeps strobes apart.
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(negedge clk_sys_in);
        io_req = '{a, 1'b1, 1'b0, d};
        @(negedge clk_sys_in);
        io_req = '0;
    endtask
    task automatic rdchk(string name, logic [5:0] a, logic [7:0] exp);
        @(negedge clk_sys_in);
        io_req = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clk_sys_in);
        io_req = '0;
        @(negedge clk_sys_in);
        check(name, {2'h0, exp}, {2'h0, rdata});
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rdchk("override", OFS_OVERRIDE, 8'h00);
        rdchk("fault_wave", OFS_FAULT_WAVE, 8'h00);
        rdchk("pll", OFS_PLL_CTRL, 8'h00);
        rdchk("temp", OFS_CNT_HIGH, 8'h00);
    endtask
    task automatic t_override();
        wr(OFS_OVERRIDE, 8'hFF);
        rdchk("override_rsvd", OFS_OVERRIDE, 8'h3F);
        en_a = 1'b1;
        wr(OFS_FAULT_WAVE, 8'h02);
        for (int i = 0; i < 3; i++)
        begin
            cmp_o = 3'(3'b100 >> i);
            cyc(3);
            check("pins_group", 10'(6'h03 << (2 * i)), 10'(pins));
        end
        port = 6'h3F;
        cmp_o = '0;
        wr(OFS_OVERRIDE, 8'h15);
        cyc(2);
        check("pins_mix", 10'h02A, 10'(pins));
    endtask
    task automatic t_modes();
        logic [2:0] exp [4] = '{MODE_FAST, MODE_PFC, MODE_SIX_SGL, MODE_SIX_DUAL};
        en_a = 1'b0;
        en_b = 1'b1;
        for (int w = 0; w < 4; w++)
        begin
            wr(OFS_FAULT_WAVE, 8'(w));
            cyc(2);
            check("mode", 10'(exp[w]), 10'(mode));
        end
        en_b = 1'b0;
        cyc(2);
        check("mode_off", 10'(MODE_NORMAL), 10'(mode));
    endtask
    // Loads in sync mode and while the dual slope runs down.
    task automatic t_counter();
        wr(OFS_CNT_HIGH, 8'h02);
        wr(OFS_CNT_LOW, 8'h55);
        check("cnt_pending", 10'h000, cnt);
        cyc(2);
        check("cnt_sync", 10'h255, cnt);
        rdchk("cnt_low", OFS_CNT_LOW, 8'h55);
        rdchk("cnt_temp", OFS_CNT_HIGH, 8'h02);
        wr(OFS_CNT_HIGH, 8'h00);
        en_a = 1'b1;
        wr(OFS_FAULT_WAVE, 8'h03);
        wr(OFS_CNT_LOW, 8'h00);
        st = 1'b1;
        cyc(24);
        wr(OFS_CNT_LOW, 8'h04);
        cyc(2);
        check("cnt_load", 10'h004, cnt);
        cyc(1);
        check("cnt_up", 10'h005, cnt);
        st = 1'b0;
        en_a = 1'b0;
    endtask
    task automatic t_pll();
        top = 10'h3FF;
        wr(OFS_PLL_CTRL, 8'h04);
        rdchk("fast_refused", OFS_PLL_CTRL, 8'h00);
        wr(OFS_PLL_CTRL, 8'h02);
        lock = 1'b1;
        rdchk("pll_on", OFS_PLL_CTRL, 8'h03);
        check("pll_start", 10'h001, 10'(pst));
        wr(OFS_PLL_CTRL, 8'h86);
        rdchk("fast_low", OFS_PLL_CTRL, 8'h87);
        check("async_sel", 10'h001, 10'(asel));
        wr(OFS_CNT_LOW, 8'h20);
        cyc(1);
        check("cnt_async", 10'h020, cnt);
        pt = 1'b1;
        st = 1'b1;
        cyc(8);
        check("cnt_low_speed", 10'h024, cnt);
        pt = 1'b0; // Timer stopped around the speed change.
        st = 1'b0;
        wr(OFS_PLL_CTRL, 8'h06);
        pt = 1'b1;
        cyc(8);
        check("cnt_full_speed", 10'h02C, cnt);
        ce = 1'b0;
        cyc(3);
        check("cnt_frozen", 10'h02C, cnt);
        ce = 1'b1;
        pt = 1'b0;
        fuse = FUSE_PLL_CODE;
        wr(OFS_PLL_CTRL, 8'h80);
        rdchk("low_refused", OFS_PLL_CTRL, 8'h03);
        fuse = 4'h0;
        wr(OFS_PLL_CTRL, 8'h00);
    endtask
    task automatic t_fault();
        int n = 0;
        gie = 1'b1;
        wr(OFS_FAULT_WAVE, 8'hA0);
        trip = 1'b1;
        cyc(3);
        trip = 1'b0;
        cyc(8);
        check("glitch", 10'h000, 10'(irq));
        trip = 1'b1;
        while (irq !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        check("filt_delay", 10'd5, 10'(n));
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        check("ack_clear", 10'h000, 10'(irq));
        gie = 1'b0;
        trip = 1'b0;
        cyc(6);
        trip = 1'b1;
        cyc(8);
        check("irq_masked", 10'h000, 10'(irq));
        rdchk("flag_set", OFS_FAULT_WAVE, 8'hA4);
        wr(OFS_FAULT_WAVE, 8'h44);
        cyc(2);
        rdchk("flag_w1c", OFS_FAULT_WAVE, 8'h40);
        trip = 1'b0;
        cyc(3);
        latch = 1'b1;
        trip = 1'b1;
        cyc(1);
        trip = 1'b0;
        cyc(4);
        check("shutdown", 10'h001, 10'(shut));
        latch = 1'b0;
        wr(OFS_FAULT_WAVE, 8'h04);
        gie = 1'b1;
        wr(OFS_FAULT_WAVE, 8'h90);
        cmp = 1'b1;
        cyc(4);
        check("cmp_off", 10'h000, 10'(irq));
        cmp = 1'b0;
        wr(OFS_FAULT_WAVE, 8'h98);
        cyc(2);
        cmp = 1'b1;
        cyc(4);
        check("cmp_rising", 10'h001, 10'(irq));
    endtask
    ////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence after five reset cycles.
    initial
    begin
        cyc(5);
        nrst_in = 1'b1;
        t_reset();
        t_override();
        t_modes();
        t_counter();
        t_pll();
        t_fault();
        complete_run();
    end
    // Watchdog at over twenty times the expected run.
    initial
    begin
        #50000;
        miscompares++;
        complete_run();
    end
endmodule // tb
bind fast_pwm_ctrl fast_pwm_ctrl_monitor fast_pwm_ctrl_monitor_i (.*);
